// *** src/dummy_removed.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** src/mamg_consts.vh ***
`ifndef MAMG_CONSTS_VH
`define MAMG_CONSTS_VH

// ****************************************
// Privilege modes
// ****************************************
`define MODE_W 3
`define MODE_BOOT 3'h0
`define MODE_TEST 3'h1
`define MODE_FW 3'h2
`define MODE_SYS 3'h3
`define MODE_USER 3'h4

// ****************************************
// Access kinds and segment entry types
// ****************************************
`define ACC_READ 2'h0
`define ACC_WRITE 2'h1
`define ACC_FETCH 2'h2
`define SEG_NORMAL 2'h0
`define SEG_END 2'h1
`define SEG_SKIP 2'h2
`define RWX_R 2
`define RWX_W 1
`define RWX_X 0

// ****************************************
// Exception causes
// ****************************************
`define EXC_NONE 4'h0
`define EXC_UNIMPL 4'h1
`define EXC_PART 4'h2
`define EXC_SEG 4'h3
`define EXC_RIGHTS 4'h4
`define EXC_ZONE 4'h5
`define EXC_MODE 4'h6
`define EXC_SFR_DENY 4'h7
`define EXC_SFR_UNIMPL 4'h8
`define EXC_FUSE 4'h9

// ****************************************
// Physical memory map
// ****************************************
`define ROM_FW_LO 24'h000000
`define ROM_FW_HI 24'h03ffff
`define ROM_APP_LO 24'h040000
`define ROM_APP_HI 24'h0fffff
`define RAM_FW_LO 24'h100000
`define RAM_FW_HI 24'h10ffff
`define RAM_APP_LO 24'h110000
`define RAM_APP_HI 24'h11ffff
`define NVM_FW_LO 24'h200000
`define NVM_FW_HI 24'h23ffff
`define NVM_APP_LO 24'h240000
`define NVM_APP_HI 24'h2ffdff
`define SEC_LO 24'h2ffe00
`define SEC_HI 24'h2fffff
`define RO_LO 24'h2ffe00
`define RO_HI 24'h2ffe1f
`define WP_LO 24'h2ffe20
`define WP_HI 24'h2ffe2f
`define WO_LO 24'h2ffe30
`define WO_HI 24'h2ffe4f
`define PDC_LO 24'h2ffe50
`define PDC_HI 24'h2ffe5f

// ****************************************
// Fuse transfer
// ****************************************
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021
`define FCFG_DELIV 0
`define FCFG_CARD_OPT 1
`define FCFG_ERASE_OPT 2
`define FCFG_CARD_DIS 3

// ****************************************
// Register offsets and fields
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FW_GRP 8'h08
`define REG_SEG_SEL 8'h0c
`define REG_SEG_CTL 8'h10
`define REG_SEG_START 8'h14
`define REG_SEG_END 8'h18
`define REG_SEG_OFS 8'h1c
`define REG_SEG_GRP 8'h20
`define CTRL_WP_LOCK 0
`define CTRL_CARD_DIS 1
`define CTRL_ERASE 2

`endif

// *** src/mamg_guard.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mamg_consts.vh"

// Functional notes
// - Boot may enter test, firmware or system; never back
// - Test mode refused once part is delivered
// - Boot mode can be left only after fuse transfer passes its CRC check
// - Fuse copy published only when CRC matches
// - Top 512 bytes of NVM are guarded rows
// - 32-byte user zone is read-only for software
// - 16-byte zone writable until software locks it
// - 32-byte zone only sets bits for software, never clears
// - Config zone only for resource configuration firmware
// - Disabled card blocks later application start-up
// - Erase option clears application NVM on request
// - Virtual addresses translated before memory interfaces
// - Boot and firmware see firmware partitions and guarded rows only
// - System and user see application partitions and the read-only, write-protect and write-once rows only
// - Test mode reaches both partitions everywhere
// - Segments written in system, checked in user
// - Each segment holds rights, bounds, offset, groups
// - Separate read, write, execute and group rights
// - Relocated address must stay in mode partition
// - Up to 64 segments; end and skip entries
// - Unimplemented or forbidden accesses raise exceptions; test mode memory accesses never do
// - Hold 16 group rights for user and firmware
// - Denied or unimplemented register access faults
module mamg_guard #(
  parameter AW = 24,
  parameter NSEG = 64,
  parameter IW = 6,
  parameter FUSE_WORDS = 8,
  parameter FAW = 4
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_mode_req,
  input wire [2:0] i_mode_sel,
  input wire i_rcfg_active,
  input wire i_cpu_req,
  input wire [1:0] i_cpu_acc,
  input wire [AW-1:0] i_cpu_vaddr,
  output reg o_mem_req,
  output reg o_mem_we,
  output reg o_mem_prog_only,
  output reg [AW-1:0] o_mem_paddr,
  input wire i_sfr_req,
  input wire [3:0] i_sfr_grp,
  input wire i_sfr_hw,
  input wire i_sfr_impl,
  output reg o_sfr_grant,
  output reg [15:0] o_sfr_rights_user,
  output reg [15:0] o_sfr_rights_fw,
  output reg [FAW-1:0] o_fuse_addr,
  input wire [15:0] i_fuse_data,
  output reg [16*(FUSE_WORDS-1)-1:0] o_hw_cfg,
  output reg o_fuse_ok,
  output reg [2:0] o_mode,
  output reg o_exc,
  output reg [3:0] o_exc_cause,
  output reg o_nv_card_disable,
  output reg o_app_erase,
  input wire i_app_erase_done
);
  localparam CW = 16 * (FUSE_WORDS - 1);
  localparam [FAW-1:0] F_LAST = FUSE_WORDS - 1;
  localparam [1:0] FL_ISSUE = 2'h0;
  localparam [1:0] FL_WAIT = 2'h1;
  localparam [1:0] FL_DONE = 2'h2;
  localparam [1:0] FL_FAIL = 2'h3;
  function [15:0] crc_step;
    input [15:0] c;
    input [15:0] d;
    integer b;
    reg [15:0] t;
    begin
      t = c ^ d;
      for (b = 0; b < 16; b = b + 1) begin
        t = t[15] ? ((t << 1) ^ `CRC_POLY) : (t << 1);
      end
      crc_step = t;
    end
  endfunction

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer n;
    begin
      be_merge = old;
      for (n = 0; n < 4; n = n + 1) begin
        if (be[n]) begin
          be_merge[n*8 +: 8] = wd[n*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // Fuse transfer during boot
  // ****************************************
  reg [1:0] fl_st_r;
  reg rd_v_r;
  reg [FAW-1:0] rd_idx_r;
  reg [15:0] crc_r;
  reg [CW-1:0] sh_r;
  wire boot_done = (fl_st_r == FL_DONE);

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fl_st_r <= FL_ISSUE;
      o_fuse_addr <= {FAW{1'b0}};
      rd_v_r <= 1'b0;
      rd_idx_r <= {FAW{1'b0}};
      crc_r <= `CRC_INIT;
      sh_r <= {CW{1'b0}};
      o_hw_cfg <= {CW{1'b0}};
      o_fuse_ok <= 1'b0;
    end else begin
      rd_v_r <= (fl_st_r == FL_ISSUE);
      rd_idx_r <= o_fuse_addr;
      if (fl_st_r == FL_ISSUE) begin
        if (o_fuse_addr == F_LAST) begin
          fl_st_r <= FL_WAIT;
        end else begin
          o_fuse_addr <= o_fuse_addr + 1'b1;
        end
      end
      if (rd_v_r) begin
        if (rd_idx_r != F_LAST) begin
          crc_r <= crc_step(crc_r, i_fuse_data);
          sh_r[rd_idx_r*16 +: 16] <= i_fuse_data;
        end else if (crc_r == i_fuse_data) begin
          o_hw_cfg <= sh_r;
          o_fuse_ok <= 1'b1;
          fl_st_r <= FL_DONE;
        end else begin
          fl_st_r <= FL_FAIL;
        end
      end
    end
  end

  wire delivered = o_hw_cfg[`FCFG_DELIV];
  wire card_opt = o_hw_cfg[`FCFG_CARD_OPT];
  wire erase_opt = o_hw_cfg[`FCFG_ERASE_OPT];
  wire app_block = card_opt && o_hw_cfg[`FCFG_CARD_DIS];

  // ****************************************
  // Mode control
  // ****************************************
  reg mode_ok;
  always @* begin
    mode_ok = 1'b0;
    if (boot_done) begin
      case (i_mode_sel)
        `MODE_BOOT: mode_ok = 1'b0;
        `MODE_TEST: mode_ok = (o_mode == `MODE_BOOT) && !delivered;
        `MODE_FW: mode_ok = 1'b1;
        `MODE_SYS: mode_ok = !app_block;
        `MODE_USER: mode_ok = !app_block &&
                              ((o_mode == `MODE_SYS) ||
                               (o_mode == `MODE_FW));
        default: mode_ok = 1'b0;
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mode <= `MODE_BOOT;
    end else if (i_mode_req && mode_ok) begin
      o_mode <= i_mode_sel;
    end
  end

  wire m_test = (o_mode == `MODE_TEST);
  wire m_user = (o_mode == `MODE_USER);
  wire m_fwlike = (o_mode == `MODE_BOOT) || (o_mode == `MODE_FW);
  wire m_sys = (o_mode == `MODE_SYS);

  // ****************************************
  // Segment table
  // ****************************************
  reg [1:0] seg_typ [0:NSEG-1];
  reg [2:0] seg_rwx [0:NSEG-1];
  reg [AW-1:0] seg_lo [0:NSEG-1];
  reg [AW-1:0] seg_hi [0:NSEG-1];
  reg [AW-1:0] seg_ofs [0:NSEG-1];
  reg [15:0] seg_grp [0:NSEG-1];
  reg [IW-1:0] seg_sel_r;
  wire [NSEG-1:0] hit;
  wire [NSEG-1:0] stop;

  genvar g;
  generate
    for (g = 0; g < NSEG; g = g + 1) begin : g_seg
      mamg_seg_match #(.AW(AW)) u_match (
        .i_vaddr(i_cpu_vaddr),
        .i_lo(seg_lo[g]),
        .i_hi(seg_hi[g]),
        .i_typ(seg_typ[g]),
        .o_hit(hit[g]),
        .o_stop(stop[g])
      );
    end
  endgenerate

  reg seg_found;
  reg seg_end;
  reg [IW-1:0] seg_idx;
  integer k;
  always @* begin
    seg_found = 1'b0;
    seg_end = 1'b0;
    seg_idx = {IW{1'b0}};
    for (k = 0; k < NSEG; k = k + 1) begin
      if (!seg_found && !seg_end) begin
        if (stop[k]) begin
          seg_end = 1'b1;
        end else if (hit[k]) begin
          seg_found = 1'b1;
          seg_idx = k[IW-1:0];
        end
      end
    end
  end

  // ****************************************
  // Translation and memory access check
  // ****************************************
  wire [AW-1:0] paddr = m_user ? i_cpu_vaddr + seg_ofs[seg_idx] :
                        i_cpu_vaddr;
  wire in_fw = (paddr <= `ROM_FW_HI) ||
               (paddr >= `RAM_FW_LO && paddr <= `RAM_FW_HI) ||
               (paddr >= `NVM_FW_LO && paddr <= `NVM_FW_HI);
  wire in_app = (paddr >= `ROM_APP_LO && paddr <= `ROM_APP_HI) ||
                (paddr >= `RAM_APP_LO && paddr <= `RAM_APP_HI) ||
                (paddr >= `NVM_APP_LO && paddr <= `NVM_APP_HI);
  wire in_sec = (paddr >= `SEC_LO) && (paddr <= `SEC_HI);
  wire in_ro = (paddr >= `RO_LO) && (paddr <= `RO_HI);
  wire in_wp = (paddr >= `WP_LO) && (paddr <= `WP_HI);
  wire in_wo = (paddr >= `WO_LO) && (paddr <= `WO_HI);
  wire in_pdc = (paddr >= `PDC_LO) && (paddr <= `PDC_HI);
  wire is_wr = (i_cpu_acc == `ACC_WRITE);
  wire [2:0] rwx = seg_rwx[seg_idx];
  wire rwx_ok = (i_cpu_acc == `ACC_READ) ? rwx[`RWX_R] :
                is_wr ? rwx[`RWX_W] : rwx[`RWX_X];
  reg wp_lock_r;
  reg [3:0] mcause;
  reg mprog;

  always @* begin
    mcause = `EXC_NONE;
    mprog = 1'b0;
    if (!in_fw && !in_app && !in_sec) begin
      if (!m_test) begin
        mcause = `EXC_UNIMPL;
      end
    end else if (m_test) begin
      mcause = `EXC_NONE;
    end else if (m_user && !seg_found) begin
      mcause = `EXC_SEG;
    end else if (m_user && !rwx_ok) begin
      mcause = `EXC_RIGHTS;
    end else if (in_sec) begin
      if (m_fwlike) begin
        if (in_pdc && !i_rcfg_active) begin
          mcause = `EXC_ZONE;
        end
      end else if (!(in_ro || in_wp || in_wo)) begin
        mcause = `EXC_ZONE;
      end else if (is_wr && in_ro) begin
        mcause = `EXC_ZONE;
      end else if (is_wr && in_wp && wp_lock_r) begin
        mcause = `EXC_ZONE;
      end else if (is_wr && in_wo) begin
        mprog = 1'b1;
      end
    end else if (m_fwlike ? !in_fw : !in_app) begin
      mcause = `EXC_PART;
    end
  end

  // ****************************************
  // Register group check
  // ****************************************
  reg [15:0] fw_grp_r;
  reg [3:0] scause;
  always @* begin
    scause = `EXC_NONE;
    if (!i_sfr_impl) begin
      scause = `EXC_SFR_UNIMPL;
    end else if (i_sfr_hw && m_user && !o_sfr_rights_user[i_sfr_grp]) begin
      scause = `EXC_SFR_DENY;
    end else if (i_sfr_hw && (o_mode == `MODE_FW) &&
                 !fw_grp_r[i_sfr_grp]) begin
      scause = `EXC_SFR_DENY;
    end
  end

  wire mbad = i_cpu_req && (mcause != `EXC_NONE);
  wire sbad = i_sfr_req && (scause != `EXC_NONE);
  wire dbad = i_mode_req && !mode_ok;
  wire fbad = rd_v_r && (rd_idx_r == F_LAST) && (crc_r != i_fuse_data);

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_prog_only <= 1'b0;
      o_mem_paddr <= {AW{1'b0}};
      o_sfr_grant <= 1'b0;
      o_sfr_rights_user <= 16'h0000;
      o_exc <= 1'b0;
      o_exc_cause <= `EXC_NONE;
    end else begin
      o_mem_req <= i_cpu_req && !mbad;
      o_mem_we <= i_cpu_req && is_wr && !mbad;
      o_mem_prog_only <= i_cpu_req && mprog && !mbad;
      o_mem_paddr <= paddr;
      o_sfr_grant <= i_sfr_req && !sbad;
      if (i_cpu_req && m_user && seg_found &&
          i_cpu_acc == `ACC_FETCH && !mbad) begin
        o_sfr_rights_user <= seg_grp[seg_idx];
      end
      o_exc <= mbad || sbad || dbad || fbad;
      if (mbad) begin
        o_exc_cause <= mcause;
      end else if (sbad) begin
        o_exc_cause <= scause;
      end else if (dbad) begin
        o_exc_cause <= `EXC_MODE;
      end else if (fbad) begin
        o_exc_cause <= `EXC_FUSE;
      end
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  wire acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  wire wr_ok = acc && i_avs_write && m_sys;
  wire [31:0] wd = i_avs_writedata & {{8{i_avs_byteenable[3]}},
                   {8{i_avs_byteenable[2]}}, {8{i_avs_byteenable[1]}},
                   {8{i_avs_byteenable[0]}}};
  wire [31:0] ctl_rd = {29'h0, o_app_erase, o_nv_card_disable, wp_lock_r};
  wire [31:0] st_rd = {19'h0, o_app_erase, o_exc_cause, o_nv_card_disable,
                       wp_lock_r, delivered, o_fuse_ok, boot_done, o_mode};
  reg [31:0] rd_mux;
  always @* begin
    case (i_avs_address)
      `REG_CTRL: rd_mux = ctl_rd;
      `REG_STATUS: rd_mux = st_rd;
      `REG_FW_GRP: rd_mux = {16'h0, fw_grp_r};
      `REG_SEG_SEL: rd_mux = {{(32-IW){1'b0}}, seg_sel_r};
      `REG_SEG_CTL: rd_mux = {27'h0, seg_rwx[seg_sel_r],
                              seg_typ[seg_sel_r]};
      `REG_SEG_START: rd_mux = {{(32-AW){1'b0}}, seg_lo[seg_sel_r]};
      `REG_SEG_END: rd_mux = {{(32-AW){1'b0}}, seg_hi[seg_sel_r]};
      `REG_SEG_OFS: rd_mux = {{(32-AW){1'b0}}, seg_ofs[seg_sel_r]};
      `REG_SEG_GRP: rd_mux = {16'h0, seg_grp[seg_sel_r]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) &&
                             o_avs_waitrequest);
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
        o_avs_readdata <= i_avs_read ? rd_mux : 32'h00000000;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  wire wr_ctl = wr_ok && (i_avs_address == `REG_CTRL);
  wire [31:0] fw_mrg = be_merge({16'h0, fw_grp_r}, i_avs_writedata,
                                i_avs_byteenable);
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_lock_r <= 1'b0;
      o_nv_card_disable <= 1'b0;
      o_app_erase <= 1'b0;
      fw_grp_r <= 16'h0000;
      o_sfr_rights_fw <= 16'h0000;
      seg_sel_r <= {IW{1'b0}};
    end else begin
      o_sfr_rights_fw <= fw_grp_r;
      if (wr_ctl && wd[`CTRL_WP_LOCK]) begin
        wp_lock_r <= 1'b1;
      end
      if (wr_ctl && wd[`CTRL_CARD_DIS] && card_opt) begin
        o_nv_card_disable <= 1'b1;
      end
      if (wr_ctl && wd[`CTRL_ERASE] && erase_opt) begin
        o_app_erase <= 1'b1;
      end else if (i_app_erase_done) begin
        o_app_erase <= 1'b0;
      end
      if (wr_ok && i_avs_address == `REG_FW_GRP) begin
        fw_grp_r <= fw_mrg[15:0];
      end
      if (wr_ok && i_avs_address == `REG_SEG_SEL) begin
        seg_sel_r <= wd[IW-1:0];
      end
    end
  end

  integer s;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (s = 0; s < NSEG; s = s + 1) begin
        seg_typ[s] <= `SEG_END;
        seg_rwx[s] <= 3'h0;
      end
    end else if (wr_ok && i_avs_address == `REG_SEG_CTL) begin
      seg_typ[seg_sel_r] <= wd[1:0];
      seg_rwx[seg_sel_r] <= wd[4:2];
    end
  end

  always @(posedge i_clk_sys) begin
    if (wr_ok) begin
      case (i_avs_address)
        `REG_SEG_START: seg_lo[seg_sel_r] <= wd[AW-1:0];
        `REG_SEG_END: seg_hi[seg_sel_r] <= wd[AW-1:0];
        `REG_SEG_OFS: seg_ofs[seg_sel_r] <= wd[AW-1:0];
        `REG_SEG_GRP: seg_grp[seg_sel_r] <= wd[15:0];
        default: ;
      endcase
    end
  end
endmodule // mamg_guard

`default_nettype wire

// *** src/mamg_seg_match.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mamg_consts.vh"

// ****************************************
// Range compare for one segment entry
// ****************************************
module mamg_seg_match #(
  parameter AW = 24
) (
  input wire [AW-1:0] i_vaddr,
  input wire [AW-1:0] i_lo,
  input wire [AW-1:0] i_hi,
  input wire [1:0] i_typ,
  output wire o_hit,
  output wire o_stop
);
  assign o_hit = (i_typ == `SEG_NORMAL) && (i_vaddr >= i_lo) &&
                 (i_vaddr <= i_hi);
  assign o_stop = (i_typ == `SEG_END);
endmodule // mamg_seg_match

`default_nettype wire

// *** verification/mamg_fuse_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mamg_consts.vh"

// ******
// Fuse array and erase engine
// ******
module mamg_fuse_model (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [3:0] i_fuse_addr,
  input wire logic [15:0] i_word0,
  input wire logic i_bad_crc,
  input wire logic i_app_erase,
  output logic [15:0] o_fuse_data,
  output logic o_erase_done
);
  logic [15:0] crc, wv;
  logic [2:0] cnt_r;
  function automatic logic [15:0] word(input logic [3:0] a);
    return (a == 4'h0) ? i_word0 : {4{a}};
  endfunction
  always_comb begin
    crc = `CRC_INIT;
    wv = 16'h0000;
    for (int i = 0; i < 7; i++) begin
      wv = word(i[3:0]);
      for (int k = 15; k >= 0; k--) begin
        crc = {crc[14:0], 1'b0} ^
          ((crc[15] ^ wv[k]) ? `CRC_POLY : 16'h0000);
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fuse_data <= 16'h0000;
      o_erase_done <= 1'b0;
      cnt_r <= 3'h0;
    end else begin
      if (i_fuse_addr < 4'h7) o_fuse_data <= word(i_fuse_addr);
      else if (i_fuse_addr == 4'h7) o_fuse_data <= crc ^ {15'h0, i_bad_crc};
      else o_fuse_data <= ~o_fuse_data;
      o_erase_done <= i_app_erase && cnt_r == 3'h4;
      cnt_r <= (i_app_erase && cnt_r != 3'h4) ? cnt_r + 3'h1 : 3'h0;
    end
  end
endmodule // mamg_fuse_model
`default_nettype wire

// *** verification/mamg_guard_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mamg_consts.vh"

// ******
// Port checker
// ******
module mamg_guard_chk #(
  parameter AW = 24,
  parameter FUSE_WORDS = 8
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire i_cpu_req,
  input wire i_sfr_req,
  input wire i_sfr_impl,
  input wire o_mem_req,
  input wire [AW-1:0] o_mem_paddr,
  input wire o_sfr_grant,
  input wire [16*(FUSE_WORDS-1)-1:0] o_hw_cfg,
  input wire [2:0] o_mode,
  input wire o_exc,
  input wire [3:0] o_exc_cause,
  input wire o_nv_card_disable,
  input wire o_app_erase
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  sequence bus_req_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence bus_ans_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  wait_one_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not after one wait cycle");
  cpu_answer_a: assert property (i_cpu_req |=> o_mem_req != o_exc)
    else $error("cpu access without single answer");
  grant_cause_a: assert property (o_mem_req |-> $past(i_cpu_req))
    else $error("memory request without cpu access");
  block_fault_a: assert property (o_exc &&
    o_exc_cause inside {[`EXC_UNIMPL:`EXC_ZONE]} |-> !o_mem_req)
    else $error("faulting access passed on");
  boot_never_a: assert property ($past(o_mode) != `MODE_BOOT
    |-> o_mode != `MODE_BOOT) else $error("boot mode entered again");
  test_entry_a: assert property (o_mode == `MODE_TEST &&
    $past(o_mode) != `MODE_TEST |-> $past(o_mode) == `MODE_BOOT)
    else $error("test mode entered from other than boot");
  test_deliv_a: assert property (o_mode == `MODE_TEST
    |-> !o_hw_cfg[`FCFG_DELIV]) else $error("test mode after delivery");
  app_part_a: assert property (o_mem_req && (o_mode == `MODE_SYS ||
    o_mode == `MODE_USER) |-> o_mem_paddr inside {[`ROM_APP_LO:`ROM_APP_HI],
    [`RAM_APP_LO:`RAM_APP_HI], [`NVM_APP_LO:`SEC_HI]})
    else $error("address outside application partition");
  sfr_cause_a: assert property (o_sfr_grant
    |-> $past(i_sfr_req && i_sfr_impl)) else $error("bad register grant");
  card_opt_a: assert property ($rose(o_nv_card_disable)
    |-> o_hw_cfg[`FCFG_CARD_OPT]) else $error("card disable without option");
  erase_opt_a: assert property ($rose(o_app_erase)
    |-> o_hw_cfg[`FCFG_ERASE_OPT]) else $error("erase without option");
endmodule // mamg_guard_chk

bind mamg_guard mamg_guard_chk #(.AW(AW), .FUSE_WORDS(FUSE_WORDS))
  mamg_guard_chk_inst (.i_clk_sys, .i_resetn, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_cpu_req, .i_sfr_req, .i_sfr_impl, .o_mem_req,
  .o_mem_paddr, .o_sfr_grant, .o_hw_cfg, .o_mode, .o_exc, .o_exc_cause,
  .o_nv_card_disable, .o_app_erase);
`default_nettype wire

// *** verification/tb_mode_and_memory_access_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mamg_consts.vh"

module tb_mode_and_memory_access_guard;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rd = 1'b0, wr = 1'b0, mode_req = 1'b0, rcfg = 1'b0, cpu_req = 1'b0;
  logic sfr_req = 1'b0, sfr_impl = 1'b0, bad_crc = 1'b1, po_s;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [2:0] mode_sel = 3'h0;
  logic [1:0] acc = 2'h0;
  logic [23:0] va = 24'h0;
  logic [3:0] grp = 4'h0;
  logic [15:0] word0 = 16'h0006;
  wire [31:0] rdat;
  wire wreq, mem_req, we, po, grant, exc, card, erase, done, fok;
  wire [23:0] pa;
  wire [15:0] ru, rf, fdat;
  wire [3:0] faddr, cause;
  wire [2:0] mode;
  wire [111:0] cfg;
  int errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  mamg_guard mamg_guard_inst (.i_clk_sys(clk), .i_resetn(resetn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_mode_req(mode_req), .i_mode_sel(mode_sel),
    .i_rcfg_active(rcfg), .i_cpu_req(cpu_req), .i_cpu_acc(acc),
    .i_cpu_vaddr(va), .o_mem_req(mem_req), .o_mem_we(we), .o_mem_prog_only(po),
    .o_mem_paddr(pa), .i_sfr_req(sfr_req), .i_sfr_grp(grp), .i_sfr_hw(1'b1),
    .i_sfr_impl(sfr_impl), .o_sfr_grant(grant), .o_sfr_rights_user(ru),
    .o_sfr_rights_fw(rf), .o_fuse_addr(faddr), .i_fuse_data(fdat),
    .o_hw_cfg(cfg), .o_fuse_ok(fok), .o_mode(mode), .o_exc(exc),
    .o_exc_cause(cause), .o_nv_card_disable(card), .o_app_erase(erase),
    .i_app_erase_done(done));
  mamg_fuse_model mamg_fuse_model_inst (.i_clk_sys(clk), .i_resetn(resetn),
    .i_fuse_addr(faddr), .i_word0(word0), .i_bad_crc(bad_crc),
    .i_app_erase(erase), .o_fuse_data(fdat), .o_erase_done(done));

  // ******
  // Shared tasks
  // ******
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task rst;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a; wr <= w; rd <= !w; wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task cpu(input logic [1:0] k, input logic [23:0] v, input logic [3:0] c,
    input logic [23:0] p);
    @(posedge clk);
    cpu_req <= 1'b1; acc <= k; va <= v;
    @(posedge clk);
    cpu_req <= 1'b0;
    @(posedge clk);
    po_s = po;
    if (c == `EXC_NONE) begin chk({we, mem_req}, {k == `ACC_WRITE, 1'b1});
      chk(pa, p); end
    else begin chk(exc, 1); chk(cause, c); chk(mem_req, 0); end
  endtask
  task mset(input logic [2:0] m, input logic ok);
    logic e;
    @(posedge clk);
    mode_req <= 1'b1; mode_sel <= m;
    @(posedge clk);
    mode_req <= 1'b0;
    @(posedge clk);
    e = exc;
    @(posedge clk);
    e = e | exc;
    if (ok) begin chk(mode, m); chk(e, 0); end
    else begin chk(e, 1); chk(cause, `EXC_MODE); end
  endtask
  task sfr(input logic [3:0] g, input logic im, input logic [3:0] c);
    @(posedge clk);
    sfr_req <= 1'b1; grp <= g; sfr_impl <= im;
    @(posedge clk);
    sfr_req <= 1'b0;
    @(posedge clk);
    if (c == `EXC_NONE) chk(grant, 1);
    else begin chk(exc, 1); chk(cause, c); chk(grant, 0); end
  endtask
  task seg(input logic [31:0] i, c, s, e, o, g);
    bus(1'b1, `REG_SEG_SEL, i); bus(1'b1, `REG_SEG_CTL, c);
    bus(1'b1, `REG_SEG_START, s); bus(1'b1, `REG_SEG_END, e);
    bus(1'b1, `REG_SEG_OFS, o); bus(1'b1, `REG_SEG_GRP, g);
  endtask
  task wait_fuse;
    int n;
    n = 0;
    while (fok !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    repeat (4) @(posedge clk);
  endtask

  // ******
  // Scenarios
  // ******
  task t_bad_crc;
    int n;
    n = 0;
    while (exc !== 1'b1 && n < 60) begin @(posedge clk); n++; end
    chk(cause, `EXC_FUSE);
    chk({fok, mode}, {1'b0, `MODE_BOOT});
    $display("test bad fuse checksum done");
  endtask
  task t_boot;
    wait_fuse();
    chk(cfg[15:0], word0);
    rdm(`REG_STATUS, 32'h3f, 32'h18);
    rdm(8'hfc, 32'hffffffff, 32'h0);
    mset(`MODE_TEST, 1);
    cpu(`ACC_READ, `ROM_FW_LO, `EXC_NONE, `ROM_FW_LO);
    cpu(`ACC_READ, `NVM_APP_LO, `EXC_NONE, `NVM_APP_LO);
    cpu(`ACC_READ, 24'h400000, `EXC_NONE, 24'h400000);
    mset(`MODE_BOOT, 0);
    mset(`MODE_FW, 1);
    cpu(`ACC_READ, 24'h100004, `EXC_NONE, 24'h100004);
    cpu(`ACC_READ, `RAM_APP_LO, `EXC_PART, 24'h0);
    cpu(`ACC_READ, 24'h400000, `EXC_UNIMPL, 24'h0);
    cpu(`ACC_READ, `PDC_LO, `EXC_ZONE, 24'h0);
    rcfg <= 1'b1;
    cpu(`ACC_READ, `PDC_LO, `EXC_NONE, `PDC_LO);
    rcfg <= 1'b0;
    $display("test boot and modes done");
  endtask
  task t_rows;
    mset(`MODE_SYS, 1);
    cpu(`ACC_READ, `NVM_APP_LO, `EXC_NONE, `NVM_APP_LO);
    cpu(`ACC_READ, `NVM_FW_LO, `EXC_PART, 24'h0);
    cpu(`ACC_WRITE, `RO_LO, `EXC_ZONE, 24'h0);
    cpu(`ACC_READ, `RO_HI, `EXC_NONE, `RO_HI);
    cpu(`ACC_WRITE, `WP_LO, `EXC_NONE, `WP_LO);
    bus(1'b1, `REG_CTRL, 32'h1);
    cpu(`ACC_WRITE, `WP_HI, `EXC_ZONE, 24'h0);
    cpu(`ACC_WRITE, `WO_LO, `EXC_NONE, `WO_LO);
    chk(po_s, 1);
    cpu(`ACC_READ, 24'h2ffe80, `EXC_ZONE, 24'h0);
    $display("test security rows done");
  endtask
  task t_segs;
    seg(0, 32'h1e, 32'h040000, 32'h04ffff, 32'h0, 32'hffff);
    seg(1, 32'h14, 32'h040000, 32'h04ffff, 32'h010000, 32'h00a5);
    seg(2, 32'h10, 32'h080000, 32'h08ffff, 32'h080000, 32'h0);
    seg(3, 32'h01, 32'h060000, 32'h06ffff, 32'h0, 32'h0);
    bus(1'b1, `REG_FW_GRP, 32'h2);
    mset(`MODE_USER, 1);
    cpu(`ACC_FETCH, 24'h040100, `EXC_NONE, 24'h050100);
    chk(ru, 16'h00a5);
    chk(rf, 16'h0002);
    cpu(`ACC_WRITE, 24'h040100, `EXC_RIGHTS, 24'h0);
    bus(1'b1, `REG_SEG_CTL, 32'h10);
    cpu(`ACC_READ, 24'h060000, `EXC_SEG, 24'h0);
    cpu(`ACC_READ, 24'h080000, `EXC_PART, 24'h0);
    sfr(4'h0, 1'b1, `EXC_NONE);
    sfr(4'h1, 1'b1, `EXC_SFR_DENY);
    sfr(4'h0, 1'b0, `EXC_SFR_UNIMPL);
    $display("test segments done");
  endtask
  task t_card;
    int n;
    mset(`MODE_FW, 1);
    mset(`MODE_SYS, 1);
    bus(1'b1, `REG_CTRL, 32'h2);
    @(posedge clk);
    chk(card, 1);
    bus(1'b1, `REG_CTRL, 32'h4);
    @(posedge clk);
    chk(erase, 1);
    n = 0;
    while (erase !== 1'b0 && n < 40) begin @(posedge clk); n++; end
    chk(erase, 0);
    word0 <= 16'h000b;
    rst();
    wait_fuse();
    mset(`MODE_TEST, 0);
    mset(`MODE_FW, 1);
    mset(`MODE_SYS, 0);
    $display("test card disable and erase done");
  endtask

  initial begin
    rst();
    t_bad_crc();
    bad_crc <= 1'b0;
    rst();
    t_boot();
    t_rows();
    t_segs();
    t_card();
    wrap_up();
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule // tb_mode_and_memory_access_guard
`default_nettype wire
